/* inc/reset_cause_pkg.sv */
package reset_cause_pkg;

  localparam logic [31:0] CAUSE_STATUS_ADDR = 32'hffff0230;
  localparam logic [31:0] CAUSE_CLEAR_ADDR  = 32'hffff0234;
  localparam logic [31:0] IRQ_STATUS_ADDR   = 32'hffff0238;
  localparam logic [31:0] IRQ_MASK_ADDR     = 32'hffff023c;

  localparam int POR_BIT = 0;
  localparam int WDT_BIT = 1;
  localparam int SW_BIT  = 2;
  localparam int EXT_BIT = 3;

  localparam int CAUSE_W = 4;

  // Status after power-on: only the power-on flag is set.
  localparam logic [3:0] CAUSE_POR_VALUE = 4'h1;
  localparam logic [3:0] IRQ_STATUS_RESET = 4'h0;
  localparam logic [3:0] IRQ_MASK_RESET   = 4'h0;
  localparam logic [31:0] READ_IDLE_VALUE = 32'h00000000;

  // Timing of the internal reset pulse.
  localparam int CLK_MHZ     = 200;
  localparam int HOLD_NS     = 100;
  localparam int HOLD_CYCLES = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CNT_W  = 8;
  localparam logic [7:0] HOLD_LOAD = 8'(HOLD_CYCLES - 1);
  localparam logic [7:0] HOLD_ZERO = 8'h00;

  typedef struct packed {
    logic ext;
    logic sw;
    logic wdt;
    logic por;
  } cause_t;

  typedef enum logic [2:0] {
    SEQ_RUN  = 3'b001,
    SEQ_HOLD = 3'b010,
    SEQ_BOOT = 3'b100
  } seq_state_t;

endpackage

/* design/reset_cause_tracker.sv */
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module reset_cause_tracker
  import reset_cause_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        ext_reset_i,
  input  wire logic        wdt_timeout_i,
  input  wire logic        kernel_done_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             sys_reset_o,
  output logic             pins_default_o,
  output logic             kernel_run_o,
  output logic             wdt_reset_o,
  output logic             ram_valid_o,
  output logic             irq_o
);

  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a == off);
  endfunction

  seq_state_t        state_reg;
  seq_state_t        state_next;
  logic [7:0]        hold_cnt_reg;
  logic [7:0]        hold_cnt_next;
  cause_t            cause_reg;
  cause_t            cause_next;
  logic [3:0]        irq_stat_reg;
  logic [3:0]        irq_stat_next;
  logic [3:0]        irq_mask_reg;
  logic [3:0]        irq_mask_next;
  logic              por_seq_reg;
  logic              por_seq_next;
  cause_t            seq_cause_reg;
  cause_t            seq_cause_next;
  logic [31:0]       rdata_next;
  logic              ram_valid_next;

  // Bus decode. Register writes are ignored while the device is held in
  // reset, because nothing upstream is allowed to run then.
  wire  bus_open       = (state_reg != SEQ_HOLD);
  wire  wr_status      = wr_i && bus_open && hit(addr_i, CAUSE_STATUS_ADDR);
  wire  wr_clear       = wr_i && bus_open && hit(addr_i, CAUSE_CLEAR_ADDR);
  wire  wr_irq_stat    = wr_i && bus_open && hit(addr_i, IRQ_STATUS_ADDR);
  wire  wr_irq_mask    = wr_i && bus_open && hit(addr_i, IRQ_MASK_ADDR);

  // Software request: a one in bit 2 of the status register, or a clear
  // write that spares the software flag while that flag is set.
  wire  sw_by_status   = wr_status && wdata_i[SW_BIT];
  wire  sw_by_clear    = wr_clear && cause_reg.sw && !wdata_i[SW_BIT];

  // Three independent reset triggers; trig.por is tied low, since power-on arrives only through reset_i.
  cause_t trig;
  assign trig.por = 1'b0;
  assign trig.ext = ext_reset_i;
  assign trig.wdt = wdt_timeout_i;
  assign trig.sw  = sw_by_status || sw_by_clear;
  wire  any_trig = |trig;

  wire  [3:0] clr_mask = wr_clear ? wdata_i[CAUSE_W-1:0] : 4'h0;

  // Cause flags: the set wins over a clear arriving in the same cycle.
  // Bits 0, 1 and 3 of a status write are not user-settable.
  assign cause_next.por = cause_reg.por & ~clr_mask[POR_BIT];
  assign cause_next.wdt = trig.wdt | (cause_reg.wdt & ~clr_mask[WDT_BIT]);
  assign cause_next.sw  = trig.sw  | (cause_reg.sw  & ~clr_mask[SW_BIT]);
  assign cause_next.ext = trig.ext | (cause_reg.ext & ~clr_mask[EXT_BIT]);

  // Sequencer. Any trigger, even during a running sequence, restarts the
  // hold window so that a long pin pulse stretches the internal reset.
  wire  hold_done = (hold_cnt_reg == HOLD_ZERO);

  always_comb begin
    state_next    = state_reg;
    hold_cnt_next = hold_cnt_reg;
    if (any_trig) begin
      state_next    = SEQ_HOLD;
      hold_cnt_next = HOLD_LOAD;
    end else begin
      unique case (state_reg)
        SEQ_HOLD: begin
          if (hold_done) begin
            state_next = SEQ_BOOT;
          end else begin
            hold_cnt_next = hold_cnt_reg - 8'h01;
          end
        end
        SEQ_BOOT: begin
          if (kernel_done_i) begin
            state_next = SEQ_RUN;
          end
        end
        SEQ_RUN: begin
          state_next = SEQ_RUN;
        end
        default: begin
          state_next    = SEQ_HOLD;
          hold_cnt_next = HOLD_LOAD;
        end
      endcase
    end
  end

  // Causes gathered over one sequence, reported as events at its end.
  wire  seq_ends = (state_reg == SEQ_BOOT) && (state_next == SEQ_RUN);
  assign seq_cause_next = any_trig ? (seq_cause_reg | trig)
                        : (seq_ends ? cause_t'(4'h0) : seq_cause_reg);

  // The power-on sequence stays marked until the hold window is left.
  assign por_seq_next = (state_reg == SEQ_HOLD) ? (por_seq_reg && !(hold_done && !any_trig))
                      : 1'b0;

  // RAM content is trusted only when the last reset was not a power-on.
  assign ram_valid_next = (state_reg == SEQ_HOLD && hold_done && !any_trig) ? !por_seq_reg
                        : ram_valid_o;

  // Interrupt status: sticky, write one to clear, set wins.
  wire  [3:0] irq_clr = wr_irq_stat ? wdata_i[CAUSE_W-1:0] : 4'h0;
  wire  [3:0] irq_set = seq_ends ? seq_cause_reg : 4'h0;
  assign irq_stat_next = irq_set | (irq_stat_reg & ~irq_clr);
  assign irq_mask_next = wr_irq_mask ? wdata_i[CAUSE_W-1:0] : irq_mask_reg;

  // Read path. Upper bits of every register read as zero, and the clear
  // register is write-only, so it reads as zero too.
  wire  [31:0] rd_mux =
      hit(addr_i, CAUSE_STATUS_ADDR) ? {28'h0000000, cause_reg} :
      hit(addr_i, CAUSE_CLEAR_ADDR)  ? READ_IDLE_VALUE :
      hit(addr_i, IRQ_STATUS_ADDR)   ? {28'h0000000, irq_stat_reg} :
      hit(addr_i, IRQ_MASK_ADDR)     ? {28'h0000000, irq_mask_reg} :
                                       READ_IDLE_VALUE;
  assign rdata_next = rd_i ? rd_mux : READ_IDLE_VALUE;

  // The cause flags live in the always-on domain: only power-on and clear-register writes clear
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cause_reg <= cause_t'(CAUSE_POR_VALUE);
    end else begin
      cause_reg <= cause_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg     <= SEQ_HOLD;
      hold_cnt_reg  <= HOLD_LOAD;
      por_seq_reg   <= 1'b1;
      seq_cause_reg <= cause_t'(CAUSE_POR_VALUE);
    end else begin
      state_reg     <= state_next;
      hold_cnt_reg  <= hold_cnt_next;
      por_seq_reg   <= por_seq_next;
      seq_cause_reg <= seq_cause_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_stat_reg <= IRQ_STATUS_RESET;
      irq_mask_reg <= IRQ_MASK_RESET;
      irq_o        <= 1'b0;
      rdata_o      <= READ_IDLE_VALUE;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_o        <= |(irq_stat_next & irq_mask_next);
      rdata_o      <= rdata_next;
    end
  end

  // Reset fan-out. All outputs are registered from the next state so
  // they move in the same cycle as the sequencer.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sys_reset_o    <= 1'b1;
      pins_default_o <= 1'b1;
      kernel_run_o   <= 1'b0;
      wdt_reset_o    <= 1'b1;
      ram_valid_o    <= 1'b0;
    end else begin
      sys_reset_o    <= (state_next == SEQ_HOLD);
      pins_default_o <= (state_next != SEQ_RUN);
      kernel_run_o   <= (state_next == SEQ_BOOT);
      wdt_reset_o    <= (state_next == SEQ_HOLD) && por_seq_next;
      ram_valid_o    <= ram_valid_next;
    end
  end

endmodule // reset_cause_tracker

/* testbench/reset_cause_tracker_props.sv */
`timescale 1ns/1ps
module reset_cause_tracker_props
  import reset_cause_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        ext_reset_i,
  input wire logic        wdt_timeout_i,
  input wire logic        kernel_done_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        sys_reset_o,
  input wire logic        pins_default_o,
  input wire logic        kernel_run_o,
  input wire logic        wdt_reset_o,
  input wire logic        ram_valid_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_read_slot: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside its slot");
  a_upper_zero: assert property (rdata_o[31:4] == 28'h0)
    else $error("unused bits read nonzero");
  a_sw_request: assert property (wr_i && addr_i == CAUSE_STATUS_ADDR && wdata_i[SW_BIT]
    && !sys_reset_o |=> sys_reset_o) else $error("software reset not started");
  a_pin_trigger: assert property (ext_reset_i |=> sys_reset_o)
    else $error("pin reset not started");
  a_wdt_keeps_timer: assert property (wdt_timeout_i && !wdt_reset_o |=>
    sys_reset_o && !wdt_reset_o) else $error("watchdog reset wrong");
  a_hold_window: assert property ($fell(sys_reset_o) |-> $past(sys_reset_o, 20))
    else $error("reset hold too short");
  a_boot_follows: assert property ($fell(sys_reset_o) |-> kernel_run_o && pins_default_o)
    else $error("kernel not run after reset");
  a_ram_valid: assert property ($fell(sys_reset_o) |-> ram_valid_o != $past(wdt_reset_o))
    else $error("ram valid wrong");
  a_boot_end: assert property (kernel_run_o && kernel_done_i |=>
    !kernel_run_o && !pins_default_o) else $error("boot did not end");
  a_pins_in_reset: assert property (sys_reset_o |-> pins_default_o && !kernel_run_o)
    else $error("pins or kernel wrong during reset");
  a_wdt_in_hold: assert property (wdt_reset_o |-> sys_reset_o)
    else $error("watchdog reset outside reset window");
endmodule // reset_cause_tracker_props
bind reset_cause_tracker reset_cause_tracker_props i_reset_cause_tracker_props (
  .clk_i          (clk_i),
  .reset_i        (reset_i),
  .ext_reset_i    (ext_reset_i),
  .wdt_timeout_i  (wdt_timeout_i),
  .kernel_done_i  (kernel_done_i),
  .addr_i         (addr_i),
  .wdata_i        (wdata_i),
  .wr_i           (wr_i),
  .rd_i           (rd_i),
  .rdata_o        (rdata_o),
  .sys_reset_o    (sys_reset_o),
  .pins_default_o (pins_default_o),
  .kernel_run_o   (kernel_run_o),
  .wdt_reset_o    (wdt_reset_o),
  .ram_valid_o    (ram_valid_o),
  .irq_o          (irq_o)
);

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
  import reset_cause_pkg::*;
  logic        clk_i = 0, reset_i = 1, ext_reset_i = 0, wdt_timeout_i = 0;
  logic        kernel_done_i = 0, wr_i = 0, rd_i = 0, rd_q = 0;
  logic [31:0] addr_i = 0, wdata_i = 0, rdata_o;
  logic        sys_reset_o, pins_default_o, kernel_run_o, wdt_reset_o, ram_valid_o, irq_o;
  logic [31:0] exp_q[$];
  int          n_fail = 0, num_checks = 0, seed = 44;
  reset_cause_tracker i_reset_cause_tracker (
    .clk_i          (clk_i),
    .reset_i        (reset_i),
    .ext_reset_i    (ext_reset_i),
    .wdt_timeout_i  (wdt_timeout_i),
    .kernel_done_i  (kernel_done_i),
    .addr_i         (addr_i),
    .wdata_i        (wdata_i),
    .wr_i           (wr_i),
    .rd_i           (rd_i),
    .rdata_o        (rdata_o),
    .sys_reset_o    (sys_reset_o),
    .pins_default_o (pins_default_o),
    .kernel_run_o   (kernel_run_o),
    .wdt_reset_o    (wdt_reset_o),
    .ram_valid_o    (ram_valid_o),
    .irq_o          (irq_o)
  );
  initial forever #2.5 clk_i = ~clk_i;
  task automatic end_sim();
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // Read data stand only in the cycle after the strobe, so the note is taken there.
  always @(posedge clk_i) begin
    if (rd_q) chk("rdata", exp_q.pop_front(), rdata_o);
    rd_q <= rd_i;
  end
  task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= w;
    rd_i <= !w;
    if (!w) exp_q.push_back(d);
    @(posedge clk_i);
    wr_i <= 0;
    rd_i <= 0;
  endtask
  task automatic boot(logic [31:0] ram);
    int i;
    for (i = 0; i < 100 && kernel_run_o !== 1'b1; i++) @(posedge clk_i);
    if (i == 100) begin
      n_fail++;
      end_sim();
    end else begin
      chk("ram_valid", ram, ram_valid_o);
      chk("pins_default", 1, pins_default_o);
      chk("wdt_reset", 0, wdt_reset_o);
      kernel_done_i <= 1;
      @(posedge clk_i);
      kernel_done_i <= 0;
      repeat (3) @(posedge clk_i);
      chk("pins_default", 0, pins_default_o);
      chk("kernel_run", 0, kernel_run_o);
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 0;
    bus(0, CAUSE_STATUS_ADDR, 32'h1);
    boot(0);
    bus(1, IRQ_MASK_ADDR, 32'hf);
    bus(0, IRQ_STATUS_ADDR, 32'h1);
    bus(0, CAUSE_CLEAR_ADDR, 32'h0);
    bus(0, 32'hffff0240, 32'h0);
    chk("irq", 1, irq_o);
    bus(1, IRQ_STATUS_ADDR, 32'h1);
    bus(1, CAUSE_CLEAR_ADDR, 32'hf);
    bus(0, CAUSE_STATUS_ADDR, 32'h0);
    chk("irq", 0, irq_o);
    bus(1, CAUSE_STATUS_ADDR, $random(seed) | 32'h4);
    boot(1);
    bus(0, CAUSE_STATUS_ADDR, 32'h4);
    bus(1, CAUSE_CLEAR_ADDR, $random(seed) & 32'hb);
    boot(1);
    bus(0, CAUSE_STATUS_ADDR, 32'h4);
    bus(1, CAUSE_CLEAR_ADDR, 32'h4);
    bus(0, CAUSE_STATUS_ADDR, 32'h0);
    chk("sys_reset", 0, sys_reset_o);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      ext_reset_i <= k == 0;
      wdt_timeout_i <= k == 1;
      @(posedge clk_i);
      ext_reset_i <= 0;
      wdt_timeout_i <= 0;
      boot(1);
      bus(0, CAUSE_STATUS_ADDR, k ? 32'h2 : 32'h8);
      bus(1, CAUSE_CLEAR_ADDR, 32'hf);
    end
    bus(0, IRQ_STATUS_ADDR, 32'he);
    chk("irq", 1, irq_o);
    bus(1, IRQ_MASK_ADDR, 32'h0);
    bus(0, IRQ_MASK_ADDR, 32'h0);
    chk("irq", 0, irq_o);
    // A second power-on in mid-run must clear every flag but the power-on one.
    @(posedge clk_i);
    reset_i <= 1;
    repeat (3) @(posedge clk_i);
    reset_i <= 0;
    chk("wdt_reset", 1, wdt_reset_o);
    chk("sys_reset", 1, sys_reset_o);
    bus(0, CAUSE_STATUS_ADDR, 32'h1);
    boot(0);
    bus(0, IRQ_STATUS_ADDR, 32'h1);
    // Let the last read reach its check before the verdict.
    repeat (2) @(posedge clk_i);
    chk("pending_reads", 0, exp_q.size());
    end_sim();
  end
endmodule // tb
